// ==== src/heater_fault_supervisor.sv ====
`timescale 1ns/1ps
module heater_fault_supervisor
(
  // clock and reset
  input  logic                                         ref_clk,
  input  logic                                         resetn,
  // user configuration
  input  logic                                         highend_variant,
  input  logic                                         phase_neutral_conn,
  input  logic                                         three_phase_load,
  input  logic                                         fan_force_on,
  input  logic [heat_sup_pkg::NCH-1:0]                 fault_suppress,
  input  logic [heat_sup_pkg::NCH-1:0]                 parallel_load,
  input  logic [heat_sup_pkg::NCH-1:0]                 two_pole_pair,
  input  logic                                         heat_request,
  // supply measurements
  input  logic                                         aux_supply_ok,
  input  logic [2:0]                                   phase_present,
  input  logic                                         phase_cw,
  input  logic [2:0][12:0]                             line_v,
  input  logic [9:0]                                   freq_meas,
  input  logic                                         freq_valid,
  input  logic                                         zero_cross,
  // temperature
  input  logic [7:0]                                   temp_int,
  input  logic [7:0]                                   temp_alarm_thr,
  // channel command and status
  input  logic [heat_sup_pkg::NCH-1:0]                 out_cmd,
  input  logic [heat_sup_pkg::NCH-1:0]                 setpoint_full,
  input  logic [heat_sup_pkg::NCH-1:0]                 setpoint_zero,
  input  logic [heat_sup_pkg::NCH-1:0]                 out_conducting,
  // channel measurements and limits
  input  logic [heat_sup_pkg::NCH-1:0][15:0]           power_meas,
  input  logic [heat_sup_pkg::NCH-1:0][15:0]           power_total,
  input  logic [heat_sup_pkg::NCH-1:0][15:0]           power_dev,
  input  logic [heat_sup_pkg::NCH-1:0][15:0]           current_meas,
  input  logic [heat_sup_pkg::NCH-1:0][15:0]           current_limit,
  input  logic [heat_sup_pkg::NCH-1:0][15:0]           fault_i_meas,
  input  logic [heat_sup_pkg::NCH-1:0][15:0]           fault_i_thr,
  // drive outputs
  output logic                                         heating_on,
  output logic [heat_sup_pkg::NCH-1:0]                 out_enable,
  output logic                                         fan_on,
  // reports
  output logic                                         fault_report,
  output logic [15:0]                                  error_code,
  output logic                                         phase_missing,
  output logic                                         phase_seq_err,
  output logic                                         volt_fault,
  output logic                                         freq_err,
  output logic                                         freq_is_60,
  output logic [9:0]                                   freq_report,
  output logic                                         meas_valid,
  output logic [7:0]                                   temp_report,
  output logic                                         over_temp,
  output logic                                         sensor_detached,
  output logic [heat_sup_pkg::NCH-1:0]                 diag_avail,
  output logic [heat_sup_pkg::NCH-1:0]                 ch_triac_short,
  output logic [heat_sup_pkg::NCH-1:0]                 ch_open,
  output logic [heat_sup_pkg::NCH-1:0]                 ch_partial,
  output logic [heat_sup_pkg::NCH-1:0]                 ch_overcurrent,
  output logic [heat_sup_pkg::NCH-1:0]                 ch_fault_current
);
  localparam int N = heat_sup_pkg::NCH;

  logic         hw_start;      // half-wave begins
  logic         sample;        // fixed status instant
  logic         v_ok;          // all phases in window
  logic         phase_ok;
  logic         ot_now;
  logic         seq_block;
  logic         heat_permit;
  logic         band_ok;
  logic         nom60;
  logic         diag_ok_all;

  // state registers
  logic         heat_reg,  heat_next;
  logic [N-1:0] oen_reg,   oen_next;
  logic         fan_reg,   fan_next;
  logic         ferr_reg,  ferr_next;
  logic [2:0]   fbad_reg,  fbad_next;
  logic [9:0]   fhold_reg, fhold_next;
  logic         f60_reg,   f60_next;
  logic         pmis_reg,  pmis_next;
  logic         seq_reg,   seq_next;
  logic         vflt_reg,  vflt_next;
  logic         ot_reg,    ot_next;
  logic         det_reg,   det_next;
  logic [7:0]   temp_reg,  temp_next;
  logic [7:0]   start_reg, start_next;
  logic [N-1:0] sht_reg,   sht_next;
  logic [N-1:0] opn_reg,   opn_next;
  logic [N-1:0] par_reg,   par_next;
  logic [N-1:0] ovc_reg,   ovc_next;
  logic [N-1:0] flc_reg,   flc_next;

  // frequency band test, used for both nominals
  function automatic logic in_band(input logic [9:0] f, input logic [9:0] lo,
                                   input logic [9:0] hi);
    in_band = (f >= lo) && (f <= hi);
  endfunction

  //////////////////////////////////////////////////////////////////////
  // half-wave timing and voltage window
  half_wave_sampler u_hw
  (
    .ref_clk    (ref_clk),
    .resetn     (resetn),
    .zero_cross (zero_cross),
    .hw_start   (hw_start),
    .sample     (sample)
  );

  volt_window_check u_vw
  (
    .line_v             (line_v),
    .phase_neutral_conn (phase_neutral_conn),
    .in_range           (v_ok)
  );

  //////////////////////////////////////////////////////////////////////
  // supply, frequency, temperature: next values
  always_comb
  begin
    phase_ok  = &phase_present;
    ot_now    = temp_int > temp_alarm_thr;
    // high-end with three-phase load needs clockwise rotation
    seq_block = highend_variant && three_phase_load && !phase_cw;
    nom60     = freq_meas >= heat_sup_pkg::F_SPLIT;
    band_ok   = nom60 ? in_band(freq_meas, heat_sup_pkg::F60_MIN, heat_sup_pkg::F60_MAX)
                      : in_band(freq_meas, heat_sup_pkg::F50_MIN, heat_sup_pkg::F50_MAX);
    pmis_next = !phase_ok;
    seq_next  = !phase_cw;
    vflt_next = !v_ok;
    ot_next   = ot_now;
    det_next  = temp_int == 8'h00;
    temp_next = temp_int;
    // fan with hysteresis; override wins
    fan_next  = fan_force_on || (temp_int >= heat_sup_pkg::FAN_ON_TEMP) ||
                (fan_reg && (temp_int >= heat_sup_pkg::FAN_OFF_TEMP));
    // frequency: count successive bad readings, keep last good one
    fbad_next  = fbad_reg;
    ferr_next  = ferr_reg;
    fhold_next = fhold_reg;
    f60_next   = f60_reg;
    if (freq_valid)
    begin
      if (band_ok)
      begin
        fbad_next  = 3'h0;
        ferr_next  = 1'b0;
        fhold_next = freq_meas;
        f60_next   = nom60;
      end
      else
      begin
        if (fbad_reg != heat_sup_pkg::FREQ_BAD_LIMIT)
          fbad_next = fbad_reg + 3'h1;
        if (fbad_reg >= heat_sup_pkg::FREQ_BAD_LIMIT - 3'h1)
          ferr_next = 1'b1;
      end
    end
    // heating permit; aux loss is silent, it sets no flag
    heat_permit = aux_supply_ok && phase_ok && v_ok && !ot_now && !seq_block &&
                  !(highend_variant && ferr_reg);
    heat_next   = heat_request && heat_permit;
    oen_next    = heat_next ? out_cmd : '0;
    // startup window restarts every time heating is off
    if (!heat_reg)
      start_next = heat_sup_pkg::STARTUP_HW;
    else if (hw_start && (start_reg != 8'h00))
      start_next = start_reg - 8'h01;
    else
      start_next = start_reg;
  end

  //////////////////////////////////////////////////////////////////////
  // per-channel diagnostics: next values
  always_comb
  begin
    // basic variant with reverse rotation cannot see a dead element at full drive
    diag_ok_all = highend_variant || phase_cw;
    sht_next = sht_reg;
    opn_next = opn_reg;
    for (int i = 0; i < N; i++)
    begin
      if (sample)
      begin
        // short: only observable while off, never at full setpoint
        sht_next[i] = !out_cmd[i] && !setpoint_full[i] && out_conducting[i] &&
                      !fault_suppress[i];
        // open path: only observable while on, never at zero setpoint
        opn_next[i] = out_cmd[i] && !setpoint_zero[i] && !out_conducting[i] &&
                      !fault_suppress[i] &&
                      (diag_ok_all || !setpoint_full[i]);
      end
      if (!heat_reg)
        opn_next[i] = 1'b0;
      par_next[i] = heat_reg && parallel_load[i] && !fault_suppress[i] &&
                    ({1'b0, power_meas[i]} + {1'b0, power_dev[i]} <
                     {1'b0, power_total[i]});
      ovc_next[i] = heat_reg && (start_reg == 8'h00) && !fault_suppress[i] &&
                    (current_meas[i] > current_limit[i]);
      flc_next[i] = heat_reg && two_pole_pair[i] && !fault_suppress[i] &&
                    (fault_i_meas[i] > fault_i_thr[i]);
    end
  end

  //////////////////////////////////////////////////////////////////////
  // registers only
  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      // flags and counters clear; the startup window starts full
      {heat_reg, oen_reg, fan_reg, ferr_reg, fbad_reg, f60_reg, pmis_reg, seq_reg} <= '0;
      {vflt_reg, ot_reg, det_reg, temp_reg, sht_reg, opn_reg, par_reg, ovc_reg, flc_reg} <= '0;
      fhold_reg <= heat_sup_pkg::FREQ_RST;
      start_reg <= heat_sup_pkg::STARTUP_HW;
    end
    else
    begin
      // grouped by concern; each next value has the width of its register
      {heat_reg, oen_reg, fan_reg, ferr_reg, fbad_reg, fhold_reg, f60_reg} <=
        {heat_next, oen_next, fan_next, ferr_next, fbad_next, fhold_next, f60_next};
      {pmis_reg, seq_reg, vflt_reg, ot_reg, det_reg, temp_reg, start_reg} <=
        {pmis_next, seq_next, vflt_next, ot_next, det_next, temp_next, start_next};
      {sht_reg, opn_reg, par_reg, ovc_reg, flc_reg} <=
        {sht_next, opn_next, par_next, ovc_next, flc_next};
    end
  end

  //////////////////////////////////////////////////////////////////////
  // outputs
  assign heating_on       = heat_reg;
  assign out_enable       = oen_reg;
  assign fan_on           = fan_reg;
  assign phase_missing    = pmis_reg;
  assign phase_seq_err    = seq_reg;
  assign volt_fault       = vflt_reg;
  assign freq_err         = ferr_reg;
  assign freq_is_60       = f60_reg;
  // high-end in frequency error shows only heat sink temperature
  assign meas_valid       = !(highend_variant && ferr_reg);
  assign freq_report      = meas_valid ? fhold_reg : 10'h000;
  assign temp_report      = temp_reg;
  assign over_temp        = ot_reg;
  assign sensor_detached  = det_reg;
  assign diag_avail       = (highend_variant || phase_cw) ? '1 : ~setpoint_full;
  assign ch_triac_short   = sht_reg;
  assign ch_open          = opn_reg;
  assign ch_partial       = par_reg;
  assign ch_overcurrent   = ovc_reg;
  assign ch_fault_current = flc_reg;
  assign fault_report     = pmis_reg || seq_reg || vflt_reg || ferr_reg || ot_reg ||
                            det_reg || (|{sht_reg, opn_reg, par_reg, ovc_reg, flc_reg});
  assign error_code       = vflt_reg ? heat_sup_pkg::ERR_VOLT :
                            (ferr_reg ? heat_sup_pkg::ERR_FREQ : heat_sup_pkg::ERR_NONE);

  //////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!resetn);

  property p_phase_stop;
    !(&phase_present) |=> phase_missing && !heating_on && fault_report;
  endproperty
  a_phase_stop: assert property (p_phase_stop) else $error("phase loss kept heating");
  property p_seq_flag;
    !phase_cw |=> phase_seq_err;
  endproperty
  a_seq_flag: assert property (p_seq_flag) else $error("reverse sequence not flagged");
  property p_seq_block;
    highend_variant && three_phase_load && !phase_cw |=> out_enable == '0;
  endproperty
  a_seq_block: assert property (p_seq_block) else $error("outputs on, bad rotation");
  property p_volt;
    !v_ok |=> volt_fault && !heating_on && error_code == heat_sup_pkg::ERR_VOLT;
  endproperty
  a_volt: assert property (p_volt) else $error("voltage fault not handled");
  property p_aux;
    !aux_supply_ok |=> out_enable == '0 && !heating_on;
  endproperty
  a_aux: assert property (p_aux) else $error("outputs on without aux supply");
  property p_freq_rise;
    $rose(freq_err) |-> $past(freq_valid) && !$past(band_ok);
  endproperty
  a_freq_rise: assert property (p_freq_rise) else $error("baseless frequency error");
  // high-end values are hidden while the error stands; heating drops on the next edge
  property p_freq_he;
    highend_variant && freq_err |-> freq_report == 10'h000 ##1 !heating_on;
  endproperty
  a_freq_he: assert property (p_freq_he) else $error("frequency stop ignored");
  property p_temp;
    temp_int > temp_alarm_thr |=> over_temp && out_enable == '0;
  endproperty
  a_temp: assert property (p_temp) else $error("overtemperature kept channels on");
  property p_detach;
    temp_int == 8'h00 |=> sensor_detached;
  endproperty
  a_detach: assert property (p_detach) else $error("detached sensor missed");
  property p_fan;
    fan_force_on |=> fan_on;
  endproperty
  a_fan: assert property (p_fan) else $error("fan override ignored");
  property p_open_gate;
    !heating_on |=> ch_open == '0;
  endproperty
  a_open_gate: assert property (p_open_gate) else $error("open fault, heating off");
endmodule

// ==== src/heat_sup_pkg.sv ====
package heat_sup_pkg;
  // channel count of one power output module
  localparam int NCH = 6;
  // clock period, used to turn times into cycle counts
  localparam int CLK_PERIOD_NS = 10;
  // status sample point after each half-wave start
  localparam int SAMPLE_DELAY_NS = 2000;
  localparam logic [11:0] SAMPLE_DELAY_CYC =
    12'((SAMPLE_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  // line voltage windows, 0.1 V units
  localparam logic [12:0] V_PP_MIN = 13'h0e10; // 360.0 V
  localparam logic [12:0] V_PP_MAX = 13'h1450; // 520.0 V
  localparam logic [12:0] V_PN_MIN = 13'h0816; // 207.0 V
  localparam logic [12:0] V_PN_MAX = 13'h0bb8; // 300.0 V
  // frequency bands, 0.1 Hz units
  localparam logic [9:0] F50_MIN = 10'h1d6; // 47.0 Hz
  localparam logic [9:0] F50_MAX = 10'h212; // 53.0 Hz
  localparam logic [9:0] F60_MIN = 10'h23a; // 57.0 Hz
  localparam logic [9:0] F60_MAX = 10'h276; // 63.0 Hz
  localparam logic [9:0] F_SPLIT = 10'h226; // 55.0 Hz, nominal 50/60 split
  // successive bad measurements before a frequency error
  localparam logic [2:0] FREQ_BAD_LIMIT = 3'h4;
  // error codes
  localparam logic [15:0] ERR_NONE = 16'h0000;
  localparam logic [15:0] ERR_VOLT = 16'h13ee; // 5102
  localparam logic [15:0] ERR_FREQ = 16'h0001;
  // fan thresholds in degrees c, with hysteresis
  localparam logic [7:0] FAN_ON_TEMP  = 8'h2d;
  localparam logic [7:0] FAN_OFF_TEMP = 8'h28;
  // half-waves of startup where overcurrent is ignored
  localparam logic [7:0] STARTUP_HW = 8'h32;
  // reset values
  localparam logic [9:0] FREQ_RST = 10'h000;
endpackage

// ==== src/half_wave_sampler.sv ====
`timescale 1ns/1ps
module half_wave_sampler
(
  // clock and reset
  input  logic ref_clk,
  input  logic resetn,
  // mains polarity pin, toggles each half-wave
  input  logic zero_cross,
  // pulses
  output logic hw_start,
  output logic sample
);
  // sampler states, one-hot
  typedef enum logic [1:0]
  {
    S_IDLE = 2'b01,
    S_WAIT = 2'b10
  } samp_state_t;

  logic [2:0]  zc_sync_reg;  // three-stage pin synchroniser
  logic        zc_lvl_reg;   // accepted level
  logic        zc_lvl_next;
  samp_state_t state_reg;
  samp_state_t state_next;
  logic [11:0] cnt_reg;      // cycles since half-wave start
  logic [11:0] cnt_next;
  logic        edge_seen;

  //////////////////////////////////////////////////////////////////////
  // level accepted only when stages two and three agree
  always_comb
  begin
    zc_lvl_next = zc_lvl_reg;
    if (zc_sync_reg[1] == zc_sync_reg[2])
      zc_lvl_next = zc_sync_reg[2];
    edge_seen  = zc_lvl_next != zc_lvl_reg;
    state_next = state_reg;
    cnt_next   = cnt_reg;
    unique case (state_reg)
      S_IDLE:
      begin
        cnt_next = 12'h000;
        if (edge_seen)
          state_next = S_WAIT;
      end
      S_WAIT:
      begin
        // a new edge restarts the timing of the fixed instant
        if (edge_seen)
          cnt_next = 12'h000;
        else if (cnt_reg == heat_sup_pkg::SAMPLE_DELAY_CYC - 12'h001)
          state_next = S_IDLE;
        else
          cnt_next = cnt_reg + 12'h001;
      end
    endcase
  end

  assign hw_start = edge_seen;
  assign sample   = (state_reg == S_WAIT) && !edge_seen &&
                    (cnt_reg == heat_sup_pkg::SAMPLE_DELAY_CYC - 12'h001);

  // registers only
  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      zc_sync_reg <= 3'h0;
      zc_lvl_reg  <= 1'b0;
      state_reg   <= S_IDLE;
      cnt_reg     <= 12'h000;
    end
    else
    begin
      zc_sync_reg <= {zc_sync_reg[1:0], zero_cross};
      zc_lvl_reg  <= zc_lvl_next;
      state_reg   <= state_next;
      cnt_reg     <= cnt_next;
    end
  end
endmodule

// ==== src/volt_window_check.sv ====
`timescale 1ns/1ps
module volt_window_check
(
  // three phase voltages, 0.1 V units
  input  logic [2:0][12:0] line_v,
  // connection type: 1 phase-neutral, 0 phase-phase
  input  logic             phase_neutral_conn,
  // all phases inside the window
  output logic             in_range
);
  logic [12:0] v_min;
  logic [12:0] v_max;
  logic [2:0]  ok;

  // window picked by connection type
  assign v_min = phase_neutral_conn ? heat_sup_pkg::V_PN_MIN : heat_sup_pkg::V_PP_MIN;
  assign v_max = phase_neutral_conn ? heat_sup_pkg::V_PN_MAX : heat_sup_pkg::V_PP_MAX;

  // one comparator pair per phase, limits inclusive
  genvar p;
  generate
    for (p = 0; p < 3; p++)
    begin : g_ph
      assign ok[p] = (line_v[p] >= v_min) && (line_v[p] <= v_max);
    end
  endgenerate

  assign in_range = &ok;
endmodule

// ==== testbench/fieldbus_ctrl_model.sv ====
`timescale 1ns/1ps
// stand-in for the higher-level controller: sends the heating command
module fieldbus_ctrl_model
(
  // clock and reset
  input  logic ref_clk,
  input  logic resetn,
  // what the bench wants the controller to ask for
  input  logic want_heat,
  // heating command towards the device
  output logic heat_request
);
  logic req_next;  // command for the next bus cycle

  ////////////////////////////////////////////////////////////////////////////////
  // cyclic data lands once per bus cycle, so the command is one cycle late
  always_comb
  begin
    req_next = want_heat;
  end

  // no heat until user data has been exchanged after reset
  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
      heat_request <= 1'h0;
    else
      heat_request <= req_next;
  end
endmodule

// ==== testbench/tb_heater_fault_supervisor.sv ====
`timescale 1ns/1ps
module tb_heater_fault_supervisor;
  // cfg {variant, pn, aux, force, cw, present}; exp {heat, volt, miss, seq, hot, det, fan, rep}
  typedef struct packed {
    logic [7:0]  cfg;
    logic [12:0] v;
    logic [7:0]  t;
    logic [7:0]  exp;
  } row_t;
  logic ref_clk, resetn, want_heat, heat_request, highend_variant, phase_neutral_conn;
  logic three_phase_load, fan_force_on, aux_supply_ok, phase_cw, freq_valid, zero_cross;
  logic heating_on, fan_on, fault_report, phase_missing, phase_seq_err, volt_fault;
  logic freq_err, freq_is_60, meas_valid, over_temp, sensor_detached;
  logic [2:0]                         phase_present;
  logic [2:0][12:0]                   line_v;
  logic [9:0]                         freq_meas, freq_report;
  logic [7:0]                         temp_int, temp_alarm_thr, temp_report, flags;
  logic [15:0]                        error_code;
  logic [heat_sup_pkg::NCH-1:0]       fault_suppress, parallel_load, two_pole_pair, out_cmd;
  logic [heat_sup_pkg::NCH-1:0]       setpoint_full, setpoint_zero, out_conducting, out_enable;
  logic [heat_sup_pkg::NCH-1:0]       diag_avail, ch_triac_short, ch_open, ch_partial;
  logic [heat_sup_pkg::NCH-1:0]       ch_overcurrent, ch_fault_current;
  logic [heat_sup_pkg::NCH-1:0][15:0] power_meas, power_total, power_dev, current_meas;
  logic [heat_sup_pkg::NCH-1:0][15:0] current_limit, fault_i_meas, fault_i_thr;
  int                                 err_count, n_tests;
  // level-monitor table: window edges, phases, rotation, temperature, fan hysteresis
  row_t rows [18] = '{
    '{8'h2f, 13'h0e10, 8'h14, 8'h80}, '{8'h2f, 13'h0e0f, 8'h14, 8'h41},
    '{8'h2f, 13'h1450, 8'h14, 8'h80}, '{8'h2f, 13'h1451, 8'h14, 8'h41},
    '{8'h6f, 13'h0816, 8'h14, 8'h80}, '{8'h6f, 13'h0815, 8'h14, 8'h41},
    '{8'h6f, 13'h0bb8, 8'h14, 8'h80}, '{8'h6f, 13'h0bb9, 8'h14, 8'h41},
    '{8'h2d, 13'h0e10, 8'h14, 8'h21}, '{8'h27, 13'h0e10, 8'h14, 8'h91},
    '{8'ha7, 13'h0e10, 8'h14, 8'h11}, '{8'h2f, 13'h0e10, 8'h51, 8'h0b},
    '{8'h2f, 13'h0e10, 8'h00, 8'h85}, '{8'h3f, 13'h0e10, 8'h14, 8'h82},
    '{8'h2f, 13'h0e10, 8'h2d, 8'h82}, '{8'h2f, 13'h0e10, 8'h2c, 8'h82},
    '{8'h2f, 13'h0e10, 8'h27, 8'h80}, '{8'h0f, 13'h0e10, 8'h14, 8'h00}};

  // status flags gathered in table order
  assign flags = {heating_on, volt_fault, phase_missing, phase_seq_err, over_temp,
                  sensor_detached, fan_on, fault_report};

  fieldbus_ctrl_model i_ctrl (.ref_clk, .resetn, .want_heat, .heat_request);

  heater_fault_supervisor i_dut
  (
    .ref_clk, .resetn, .highend_variant, .phase_neutral_conn, .three_phase_load,
    .fan_force_on, .fault_suppress, .parallel_load, .two_pole_pair, .heat_request,
    .aux_supply_ok, .phase_present, .phase_cw, .line_v, .freq_meas, .freq_valid,
    .zero_cross, .temp_int, .temp_alarm_thr, .out_cmd, .setpoint_full, .setpoint_zero,
    .out_conducting, .power_meas, .power_total, .power_dev, .current_meas,
    .current_limit, .fault_i_meas, .fault_i_thr, .heating_on, .out_enable, .fan_on,
    .fault_report, .error_code, .phase_missing, .phase_seq_err, .volt_fault, .freq_err,
    .freq_is_60, .freq_report, .meas_valid, .temp_report, .over_temp, .sensor_detached,
    .diag_avail, .ch_triac_short, .ch_open, .ch_partial, .ch_overcurrent, .ch_fault_current
  );

  ////////////////////////////////////////////////////////////////////////////////
  // inputs move 1 ns after the edge so the dut never races the bench
  task automatic step(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask

  task automatic check(input string name, input logic [15:0] exp, input logic [15:0] got);
    n_tests++;
    if (got !== exp)
    begin
      err_count++;
      $display("mismatch %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic apply(input row_t r);
    {highend_variant, phase_neutral_conn, aux_supply_ok, fan_force_on, phase_cw,
     phase_present} = r.cfg;
    line_v = {3{r.v}};
    temp_int = r.t;
  endtask

  // one-cycle valid pulse, then an idle edge so valid is never set twice at once
  task automatic freq_pulse(input logic [9:0] f);
    freq_meas = f;
    freq_valid = 1'h1;
    step(1);
    freq_valid = 1'h0;
    step(1);
  endtask

  // half-waves of gap cycles each; a new edge restarts the sample wait
  task automatic half_waves(input int n, input int gap);
    repeat (n)
    begin
      zero_cross = ~zero_cross;
      step(gap);
    end
  endtask

  task automatic complete_run;
    if (err_count == 0 && n_tests > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    ref_clk = 1'h0;
    forever #5 ref_clk = ~ref_clk;
  end

  // watchdog, the run needs fewer than two thousand cycles
  initial
  begin
    repeat (20000) @(posedge ref_clk);
    err_count++;
    complete_run();
  end

  initial
  begin
    err_count = 0;
    n_tests = 0;
    {resetn, freq_valid, zero_cross, fault_suppress, parallel_load, two_pole_pair} = '0;
    {setpoint_full, setpoint_zero, out_conducting, freq_meas} = '0;
    {power_meas, power_total, power_dev, current_meas, current_limit, fault_i_meas} = '0;
    fault_i_thr = '0;
    {want_heat, three_phase_load} = 2'h3;
    out_cmd = 6'h3f;
    temp_alarm_thr = 8'h50;
    apply(rows[0]);
    repeat (10) @(posedge ref_clk);
    #1;
    resetn = 1'h1;
    // level monitors
    foreach (rows[i])
    begin
      apply(rows[i]);
      step(3);
      check("flags", {8'h00, rows[i].exp}, {8'h00, flags});
      check("hot", {8'h00, rows[i].t}, {8'h00, temp_report});
      check("code", rows[i].exp[6] ? heat_sup_pkg::ERR_VOLT : 16'h0000, error_code);
      check("enable", {10'h000, rows[i].exp[7] ? 6'h3f : 6'h00},
            {10'h000, out_enable});
    end
    // frequency: band edges, four bad readings, variant reactions
    apply(rows[0]);
    freq_pulse(10'h276);
    check("f60", {6'h01, 10'h276}, {5'h00, freq_is_60, freq_report});
    freq_pulse(10'h1d6);
    check("f50", {6'h00, 10'h1d6}, {5'h00, freq_is_60, freq_report});
    freq_pulse(10'h1d5);
    freq_pulse(10'h213);
    freq_pulse(10'h239);
    check("ferr early", 16'h0000, {15'h0000, freq_err});
    freq_pulse(10'h277);
    check("ferr", 16'h0007, {13'h0000, freq_err, heating_on, fault_report});
    check("fhold", {6'h00, 10'h1d6}, {6'h00, freq_report});
    check("fcode", heat_sup_pkg::ERR_FREQ, error_code);
    highend_variant = 1'h1;
    step(2);
    check("fhigh", 16'h0000, {4'h0, heating_on, meas_valid, freq_report});
    check("temp", 16'h0014, {8'h00, temp_report});
    freq_pulse(10'h1f4);
    step(1);
    check("frecover", 16'h0003, {13'h0000, freq_err, heating_on, meas_valid});
    highend_variant = 1'h0;
    // channel diagnostics: ch0 open, ch2 short, ch3 full, ch4 muted, ch5 zero
    out_cmd = 6'h23;
    out_conducting = 6'h1e;
    fault_suppress = 6'h10;
    setpoint_full = 6'h08;
    setpoint_zero = 6'h20;
    parallel_load = 6'h02;
    two_pole_pair = 6'h04;
    power_meas[1] = 16'h0010;
    power_total[1] = 16'h0100;
    power_dev[1] = 16'h0010;
    current_meas[0] = 16'h0100;
    current_limit[0] = 16'h0080;
    fault_i_meas[2] = 16'h0020;
    fault_i_thr[2] = 16'h0010;
    step(3);
    check("partial", 16'h0002, {10'h000, ch_partial});
    check("fcurrent", 16'h0004, {10'h000, ch_fault_current});
    check("ocstart", 16'h0000, {10'h000, ch_overcurrent});
    check("enable ch", 16'h0023, {10'h000, out_enable});
    phase_cw = 1'h0;
    step(2);
    check("diag", 16'h0037, {10'h000, diag_avail});
    phase_cw = 1'h1;
    half_waves(1, 100);
    check("presample", 16'h0000, {4'h0, ch_triac_short, ch_open});
    step(150);
    check("sample", 16'h0101, {4'h0, ch_triac_short, ch_open});
    half_waves(55, 10);
    step(250);
    check("oc", 16'h0001, {10'h000, ch_overcurrent});
    want_heat = 1'h0;
    step(4);
    half_waves(1, 250);
    check("heat off", 16'h0100, {4'h0, ch_triac_short, ch_open});
    // reset in mid-run clears every registered output
    resetn = 1'h0;
    step(1);
    check("reset", 16'h0000,
          {1'h0, heating_on, fan_on, fault_report, ch_triac_short, out_enable});
    resetn = 1'h1;
    complete_run();
  end
endmodule
